// >>> core/fsr_pkg.sv
package fsr_pkg;
  // ==================================================
  // Timebase
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 1;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int CW = 24;
  // ==================================================
  // Intervals, figure in its own unit
  localparam int FILT_US = 50;
  localparam int TMO_MS = 20;
  localparam int HOLD_MS = 1;
  localparam int STBY_S = 1;
  localparam int PWRUP_S = 5;
  localparam int FILT_TICKS = FILT_US / TICK_US;
  localparam int TMO_TICKS = TMO_MS * 1000 / TICK_US;
  localparam int HOLD_TICKS = HOLD_MS * 1000 / TICK_US;
  localparam int STBY_TICKS = STBY_S * 1000000 / TICK_US;
  localparam int PWRUP_TICKS = PWRUP_S * 1000000 / TICK_US;
  // ==================================================
  // Serial port
  localparam logic [6:0] DEV_ADDR = 7'h3c;
  localparam logic [7:0] REG_WARNING_THRESHOLD_CONTROL = 8'h09;
  localparam logic [7:0] REG_PGMSK = 8'h0a;
  localparam logic [7:0] REG_IRQMSK = 8'h0b;
  localparam logic [7:0] REG_CLEAR_INTERRUPT_CMD = 8'h0c;
  localparam logic [7:0] REG_HRESET = 8'h0d;
  localparam logic [7:0] REG_PGHELD = 8'h0e;
  localparam logic [7:0] REG_PGLIVE = 8'h0f;
  localparam logic [7:0] REG_INTERRUPT_EVENT_STATUS = 8'h10;
  // ==================================================
  // Reset values and fields
  localparam logic [7:0] WARNING_THRESHOLD_CONTROL_RST = 8'h00;
  localparam logic [7:0] PGMSK_RST = 8'hef;
  localparam logic [7:0] IRQMSK_RST = 8'h00;
  localparam logic [7:0] PG_USED = 8'hef;
  localparam logic [7:0] IRQMSK_USED = 8'h7c;
  localparam int UVW_LSB = 2;
  localparam int OTW_LSB = 0;
  localparam int IRQ_HARD_RESET_CMD = 1;
  localparam int IRQ_PGTMO = 2;
  localparam int IRQ_UVW = 3;
  localparam int IRQ_UVS = 4;
  localparam int IRQ_OTW = 5;
  localparam int IRQ_OTS = 6;
  // ==================================================
  // States
  typedef enum logic [1:0] {PS_RESET_WAIT, PS_ON, PS_STANDBY, PS_HARD_RESET_CMD_TIMER} fsr_pstate_type;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_PTR, I_DATA, I_READ} fsr_iphase_type;
endpackage

// >>> core/fsr_fault_irq.sv
`timescale 1ns/1ps
module fsr_fault_irq
  import fsr_pkg::*;
#(
  parameter int FILT_T = fsr_pkg::FILT_TICKS,
  parameter int TMO_T = fsr_pkg::TMO_TICKS,
  parameter int HOLD_T = fsr_pkg::HOLD_TICKS,
  parameter int STBY_T = fsr_pkg::STBY_TICKS,
  parameter int PWRUP_T = fsr_pkg::PWRUP_TICKS
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Comparators and supervisors
  input wire logic SUPPLY_LOW_FAULT,
  input wire logic SUPPLY_RISE_OK,
  input wire logic SUPPLY_LOW_WARN,
  input wire logic DIE_TOO_HOT_FAULT,
  input wire logic DIE_TOO_HOT_WARN,
  input wire logic INTERFACE_SUPPLY_LOW,
  input wire logic MASTER_POWER_REQUEST,
  // Regulator flags
  input wire logic [7:0] REG_ENABLED,
  input wire logic [7:0] REG_OUT_LOW,
  input wire logic [7:0] REG_OUT_OK,
  // Serial port
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Status pins
  output logic POWER_GOOD_OUT,
  output logic POWER_GOOD_OE,
  output logic IRQ_N_OUT,
  output logic IRQ_N_OE,
  // Controller
  output fsr_pkg::fsr_pstate_type POWER_STATE,
  output logic REGS_ALLOWED,
  output logic CMD_DEFAULTS,
  output logic [2:0] SUPPLY_WARN_SEL,
  output logic [1:0] DIE_WARN_SEL
);
  import fsr_pkg::*;

  // ==================================================
  // Input synchronisers
  logic [32:0] sync1_q, sync2_q;
  logic s_vflt, s_rise, s_vwarn, s_hot, s_dwarn, s_iflow, s_req, scl, sda;
  logic [7:0] s_en, s_low, s_ok;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {SUPPLY_LOW_FAULT, SUPPLY_RISE_OK, SUPPLY_LOW_WARN, DIE_TOO_HOT_FAULT, DIE_TOO_HOT_WARN,
                  INTERFACE_SUPPLY_LOW, MASTER_POWER_REQUEST, REG_ENABLED, REG_OUT_LOW, REG_OUT_OK, SCL, SDA_IN};
      sync2_q <= sync1_q;
    end
  end

  assign {s_vflt, s_rise, s_vwarn, s_hot, s_dwarn, s_iflow, s_req, s_en, s_low, s_ok, scl, sda} = sync2_q;

  // ==================================================
  // Timebase
  logic [7:0] tick_cnt_q;
  logic tick;

  assign tick = (tick_cnt_q == 8'(TICK_CYC - 1));

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tick_cnt_q <= 8'h00;
    end else begin
      tick_cnt_q <= tick ? 8'h00 : tick_cnt_q + 8'h01;
    end
  end

  // Saturating, so a long condition never wraps back under its limit
  function automatic logic [CW-1:0] cnt_next(input logic cond, input logic tk, input logic [CW-1:0] cnt);
    if (!cond) begin
      return '0;
    end else if (tk && (cnt != '1)) begin
      return cnt + 1'b1;
    end
    return cnt;
  endfunction

  // ==================================================
  // Power good monitor
  logic [7:0] act_low, live_status, held_status, pgmsk_q;
  logic [CW-1:0] filt_cnt_q, tmo_cnt_q, hold_cnt_q;
  logic [CW-1:0] held_cnt_q [8];
  logic pin_low_cond, filtered, tmo_lvl, all_off, all_good, pg_low_d;

  assign act_low = s_low & s_en & PG_USED;
  assign live_status = ~act_low & PG_USED;
  assign pin_low_cond = |(act_low & pgmsk_q);
  assign filtered = pin_low_cond && (filt_cnt_q >= CW'(FILT_T));
  assign tmo_lvl = pin_low_cond && (tmo_cnt_q >= CW'(TMO_T));
  assign all_off = ~|(s_en & PG_USED);
  assign all_good = &(s_ok | ~s_en | ~pgmsk_q | ~PG_USED);
  assign pg_low_d = all_off || !all_good || filtered || (hold_cnt_q != '0);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      filt_cnt_q <= '0;
      tmo_cnt_q <= '0;
    end else begin
      filt_cnt_q <= cnt_next(pin_low_cond, tick, filt_cnt_q);
      tmo_cnt_q <= cnt_next(pin_low_cond, tick, tmo_cnt_q);
    end
  end

  // hold starts when the filtered low ends
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      hold_cnt_q <= '0;
      POWER_GOOD_OE <= 1'b1;
    end else begin
      if (filtered) begin
        hold_cnt_q <= CW'(HOLD_T);
      end else if (tick && (hold_cnt_q != '0)) begin
        hold_cnt_q <= hold_cnt_q - 1'b1;
      end
      POWER_GOOD_OE <= pg_low_d;
    end
  end

  // held copy keeps each low for the hold time
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < 8; i++) begin
        held_cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (act_low[i]) begin
          held_cnt_q[i] <= CW'(HOLD_T);
        end else if (tick && (held_cnt_q[i] != '0)) begin
          held_cnt_q[i] <= held_cnt_q[i] - 1'b1;
        end
      end
    end
  end

  always_comb begin
    held_status = live_status;
    for (int i = 0; i < 8; i++) begin
      if (held_cnt_q[i] != '0) begin
        held_status[i] = 1'b0;
      end
    end
  end

  // ==================================================
  // Serial port
  fsr_iphase_type ph_q;
  logic scl_p_q, sda_p_q, in_ack_q, ack_q, rd_q, clr_p_q, hard_reset_cmd_p_q;
  logic start, stop, rise, fall, commit, clr_go, hard_reset_cmd_go;
  logic [3:0] bcnt_q;
  logic [7:0] sh_q, tx_q, ptr_q, rd_data, st_warning_threshold_control_q, st_pgmsk_q, st_irqmsk_q;
  logic [7:0] warning_threshold_control_q, irqmsk_q, interrupt_event_status_q;

  assign start = scl && scl_p_q && sda_p_q && !sda;
  assign stop = scl && scl_p_q && !sda_p_q && sda;
  assign rise = scl && !scl_p_q;
  assign fall = !scl && scl_p_q;
  // command set acted on only at stop
  assign commit = stop && (ph_q != I_IDLE);
  assign clr_go = commit && clr_p_q;
  assign hard_reset_cmd_go = commit && hard_reset_cmd_p_q;

  always_comb begin
    unique case (ptr_q)
      REG_WARNING_THRESHOLD_CONTROL: rd_data = warning_threshold_control_q;
      REG_PGMSK: rd_data = pgmsk_q;
      REG_IRQMSK: rd_data = irqmsk_q;
      REG_PGHELD: rd_data = held_status;
      REG_PGLIVE: rd_data = live_status;
      REG_INTERRUPT_EVENT_STATUS: rd_data = interrupt_event_status_q;
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl;
      sda_p_q <= sda;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ph_q <= I_IDLE;
      {in_ack_q, ack_q, rd_q, clr_p_q, hard_reset_cmd_p_q} <= '0;
      {bcnt_q, sh_q, tx_q, ptr_q} <= '0;
      st_warning_threshold_control_q <= WARNING_THRESHOLD_CONTROL_RST;
      st_pgmsk_q <= PGMSK_RST;
      st_irqmsk_q <= IRQMSK_RST;
    end else if (s_iflow || hard_reset_cmd_go) begin
      // port cleared, staged values back to defaults
      ph_q <= I_IDLE;
      {in_ack_q, ack_q, rd_q, clr_p_q, hard_reset_cmd_p_q} <= '0;
      bcnt_q <= 4'h0;
      st_warning_threshold_control_q <= WARNING_THRESHOLD_CONTROL_RST;
      st_pgmsk_q <= PGMSK_RST;
      st_irqmsk_q <= IRQMSK_RST;
    end else if (start) begin
      // Repeated start keeps staged writes and pending commands
      ph_q <= I_ADDR;
      {in_ack_q, ack_q, rd_q} <= '0;
      bcnt_q <= 4'h0;
    end else if (stop) begin
      ph_q <= I_IDLE;
      {in_ack_q, ack_q, rd_q, clr_p_q, hard_reset_cmd_p_q} <= '0;
    end else if (ph_q != I_IDLE) begin
      // Ack bit shifted too, so a read sees the master's answer
      if (rise) begin
        sh_q <= {sh_q[6:0], sda};
        if (!in_ack_q) begin
          bcnt_q <= bcnt_q + 4'h1;
        end
      end
      if (fall) begin
        if (in_ack_q) begin
          in_ack_q <= 1'b0;
          ack_q <= 1'b0;
          bcnt_q <= 4'h0;
          // No reload after a not-acknowledge, else the line stays low and hides the stop
          if ((ph_q == I_READ) && !sh_q[0]) begin
            tx_q <= rd_data;
            rd_q <= 1'b1;
          end
        end else if (bcnt_q == 4'h8) begin
          in_ack_q <= 1'b1;
          rd_q <= 1'b0;
          unique case (ph_q)
            I_ADDR: begin
              if (sh_q[7:1] == DEV_ADDR) begin
                ack_q <= 1'b1;
                ph_q <= sh_q[0] ? I_READ : I_PTR;
              end else begin
                ph_q <= I_IDLE;
              end
            end
            I_PTR: begin
              ack_q <= 1'b1;
              ptr_q <= sh_q;
              // command pointers carry no data byte
              if (sh_q == REG_CLEAR_INTERRUPT_CMD) begin
                clr_p_q <= 1'b1;
              end
              if (sh_q == REG_HRESET) begin
                hard_reset_cmd_p_q <= 1'b1;
              end
              ph_q <= ((sh_q == REG_CLEAR_INTERRUPT_CMD) || (sh_q == REG_HRESET)) ? I_PTR : I_DATA;
            end
            I_DATA: begin
              ack_q <= 1'b1;
              ph_q <= I_PTR;
              if (ptr_q == REG_WARNING_THRESHOLD_CONTROL) begin
                st_warning_threshold_control_q <= sh_q;
              end
              if (ptr_q == REG_PGMSK) begin
                st_pgmsk_q <= sh_q;
              end
              if (ptr_q == REG_IRQMSK) begin
                st_irqmsk_q <= sh_q;
              end
            end
            I_READ: begin
              // Nothing here; master acknowledge checked at the next fall
            end
            I_IDLE: begin
            end
          endcase
        end else if (rd_q) begin
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  assign SDA_OUT = 1'b0;
  assign SDA_OE = ack_q || (rd_q && !tx_q[7]);

  // ==================================================
  // Command registers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      warning_threshold_control_q <= WARNING_THRESHOLD_CONTROL_RST;
      pgmsk_q <= PGMSK_RST;
      irqmsk_q <= IRQMSK_RST;
    end else if (s_iflow || hard_reset_cmd_go) begin
      warning_threshold_control_q <= WARNING_THRESHOLD_CONTROL_RST;
      pgmsk_q <= PGMSK_RST;
      irqmsk_q <= IRQMSK_RST;
    end else if (commit) begin
      warning_threshold_control_q <= st_warning_threshold_control_q;
      pgmsk_q <= st_pgmsk_q;
      irqmsk_q <= st_irqmsk_q;
    end
  end

  assign CMD_DEFAULTS = s_iflow || hard_reset_cmd_go;
  assign SUPPLY_WARN_SEL = warning_threshold_control_q[UVW_LSB+:3];
  assign DIE_WARN_SEL = warning_threshold_control_q[OTW_LSB+:2];

  // ==================================================
  // Interrupt status
  logic [4:0] prev_q;
  logic [7:0] ev;
  logic irq_d;

  // edge events, one per status bit 1 to 6
  always_comb begin
    ev = 8'h00;
    ev[IRQ_HARD_RESET_CMD] = hard_reset_cmd_go;
    ev[IRQ_PGTMO] = tmo_lvl && !prev_q[0];
    ev[IRQ_UVW] = s_vwarn && !prev_q[1];
    ev[IRQ_UVS] = s_vflt && !prev_q[2];
    ev[IRQ_OTW] = s_dwarn && !prev_q[3];
    ev[IRQ_OTS] = s_hot && !prev_q[4];
  end

  assign irq_d = |(interrupt_event_status_q & ~(irqmsk_q & IRQMSK_USED));

  // only a clear access drops bits; a new event wins
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      prev_q <= '0;
      interrupt_event_status_q <= 8'h00;
      IRQ_N_OE <= 1'b0;
    end else begin
      prev_q <= {s_hot, s_dwarn, s_vflt, s_vwarn, tmo_lvl};
      interrupt_event_status_q <= (clr_go ? 8'h00 : interrupt_event_status_q) | ev;
      IRQ_N_OE <= irq_d;
    end
  end

  assign IRQ_N_OUT = 1'b0;
  assign POWER_GOOD_OUT = 1'b0;

  // ==================================================
  // State controller
  fsr_pstate_type state_q, state_d;
  logic [CW-1:0] st_cnt_q, pu_cnt_q;
  logic crossed_q, inhibit, flt;

  // hot comparator carries the 155/140 hysteresis
  assign flt = s_vflt || s_hot;
  // inhibit after five seconds without a rising crossing
  assign inhibit = !crossed_q && (pu_cnt_q >= CW'(PWRUP_T));

  always_comb begin
    state_d = state_q;
    if (hard_reset_cmd_go) begin
      state_d = PS_HARD_RESET_CMD_TIMER;
    end else begin
      unique case (state_q)
        PS_RESET_WAIT: begin
          if (s_req && !flt && !inhibit) begin
            state_d = PS_ON;
          end
        end
        // faults move state whatever the mask
        PS_ON: begin
          if (flt || !s_req) begin
            state_d = PS_STANDBY;
          end
        end
        // request during standby restarts at once
        PS_STANDBY: begin
          if (s_req && !flt) begin
            state_d = PS_ON;
          end else if (st_cnt_q >= CW'(STBY_T)) begin
            state_d = PS_RESET_WAIT;
          end
        end
        PS_HARD_RESET_CMD_TIMER: begin
          if (st_cnt_q >= CW'(STBY_T)) begin
            state_d = PS_RESET_WAIT;
          end
        end
      endcase
    end
  end

  // state timer restarts on every state change
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= PS_RESET_WAIT;
      st_cnt_q <= '0;
      pu_cnt_q <= '0;
      crossed_q <= 1'b0;
      REGS_ALLOWED <= 1'b0;
    end else begin
      state_q <= state_d;
      st_cnt_q <= cnt_next(state_d == state_q, tick, st_cnt_q);
      pu_cnt_q <= cnt_next(!crossed_q, tick, pu_cnt_q);
      crossed_q <= crossed_q || s_rise;
      REGS_ALLOWED <= (state_d == PS_ON) && !inhibit;
    end
  end

  assign POWER_STATE = state_q;

  // ==================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  chk_fault_standby: assert property (
    (state_q == PS_ON && flt && !hard_reset_cmd_go) |=> state_q == PS_STANDBY) else $error("fault did not force standby");
  chk_standby_resume: assert property (
    (state_q == PS_STANDBY && s_req && !flt && !hard_reset_cmd_go) |=> state_q == PS_ON) else $error("no resume");
  chk_pg_all_off: assert property (
    all_off |=> POWER_GOOD_OE) else $error("power good released with all off");
  chk_pg_hold_time: assert property (
    $fell(filtered) |-> ##1 POWER_GOOD_OE [*8]) else $error("power good hold missing");
  chk_held_vs_live: assert property (
    (held_status & ~live_status) == 8'h00) else $error("held status shows ok while live low");
  chk_held_keeps_low: assert property (
    (act_low != 8'h00) |=> (held_status & $past(act_low)) == 8'h00) else $error("held status missed a low");
  chk_tmo_event: assert property (
    $rose(tmo_lvl) |=> interrupt_event_status_q[IRQ_PGTMO]) else $error("timeout bit not set");
  chk_stat_sticky: assert property (
    !clr_go |=> (interrupt_event_status_q & $past(interrupt_event_status_q)) == $past(interrupt_event_status_q)) else $error("status bit lost");
  chk_irq_mask: assert property (
    ##1 (IRQ_N_OE == $past(irq_d))) else $error("interrupt pin not following masked status");
  chk_hard_reset_cmd_defaults: assert property (
    hard_reset_cmd_go |=> (warning_threshold_control_q == WARNING_THRESHOLD_CONTROL_RST && irqmsk_q == IRQMSK_RST && state_q == PS_HARD_RESET_CMD_TIMER))
    else $error("hard reset incomplete");
  chk_commit_stop: assert property (
    (!commit && !s_iflow) |=> $stable(warning_threshold_control_q) && $stable(pgmsk_q)) else $error("register changed before stop");
endmodule

// >>> tb/fsr_host.sv
`timescale 1ns/1ps
// ========
// Serial bus host, open drain, bus pulled up when released
module fsr_host (
  // Bus wires
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam real Q = 31.25;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Also repeated start; clock stands high outside frames
  task automatic start();
    #(Q) sda_low = 1'b0;
    #(Q) scl = 1'b1;
    #(2*Q) sda_low = 1'b1;
    #(2*Q) scl = 1'b0;
  endtask
  task automatic stop();
    #(Q) sda_low = 1'b1;
    #(Q) scl = 1'b1;
    #(2*Q) sda_low = 1'b0;
    #(2*Q);
  endtask
  // Eight bits MSB first, ninth released for acknowledge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic [8:0] sh;
    sh = {tx, 1'b1};
    for (int i = 0; i < 9; i++) begin
      #(Q) sda_low = ~sh[8];
      #(Q) scl = 1'b1;
      #(Q) sh = {sh[7:0], sda};
      #(Q) scl = 1'b0;
    end
    rx = sh[8:1];
    ack = ~sh[0];
  endtask
  // pointer-only commands carry no data byte
  task automatic wr(input logic [7:0] p, input logic [7:0] d, input bit dat, output logic ok);
    logic [7:0] r;
    logic a, b, c;
    start();
    xfer(8'h78, r, a);
    xfer(p, r, b);
    c = 1'b1;
    if (dat) begin
      xfer(d, r, c);
    end
    stop();
    ok = a & b & c;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic a, b, c, n;
    start();
    xfer(8'h78, r, a);
    xfer(p, r, b);
    start();
    xfer(8'h79, r, c);
    xfer(8'hff, d, n);
    stop();
    ok = a & b & c;
  endtask
endmodule

// >>> tb/fault_status_irq_reporting_tb.sv
`timescale 1ns/1ps
module fault_status_irq_reporting_tb;
  import fsr_pkg::*;
  // ========
  // Pins
  logic CLK, NRST, SUPPLY_LOW_FAULT, SUPPLY_RISE_OK, SUPPLY_LOW_WARN, DIE_TOO_HOT_FAULT;
  logic DIE_TOO_HOT_WARN, INTERFACE_SUPPLY_LOW, MASTER_POWER_REQUEST;
  logic [7:0] REG_ENABLED, REG_OUT_LOW, REG_OUT_OK;
  logic SDA_OUT, SDA_OE, POWER_GOOD_OUT, POWER_GOOD_OE, IRQ_N_OUT, IRQ_N_OE;
  logic REGS_ALLOWED, CMD_DEFAULTS, scl, host_low, sda;
  logic [2:0] SUPPLY_WARN_SEL;
  logic [1:0] DIE_WARN_SEL;
  fsr_pstate_type POWER_STATE;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  // Pull-up wins unless a party pulls low
  assign sda = ~(host_low | SDA_OE);
  // Short intervals keep the run brief
  fsr_fault_irq #(.FILT_T(3), .TMO_T(40), .HOLD_T(15), .STBY_T(20), .PWRUP_T(30)) u_dut (
    .CLK(CLK), .NRST(NRST), .SUPPLY_LOW_FAULT(SUPPLY_LOW_FAULT), .SUPPLY_RISE_OK(SUPPLY_RISE_OK),
    .SUPPLY_LOW_WARN(SUPPLY_LOW_WARN), .DIE_TOO_HOT_FAULT(DIE_TOO_HOT_FAULT),
    .DIE_TOO_HOT_WARN(DIE_TOO_HOT_WARN), .INTERFACE_SUPPLY_LOW(INTERFACE_SUPPLY_LOW),
    .MASTER_POWER_REQUEST(MASTER_POWER_REQUEST), .REG_ENABLED(REG_ENABLED),
    .REG_OUT_LOW(REG_OUT_LOW), .REG_OUT_OK(REG_OUT_OK), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .POWER_GOOD_OUT(POWER_GOOD_OUT),
    .POWER_GOOD_OE(POWER_GOOD_OE), .IRQ_N_OUT(IRQ_N_OUT), .IRQ_N_OE(IRQ_N_OE),
    .POWER_STATE(POWER_STATE), .REGS_ALLOWED(REGS_ALLOWED), .CMD_DEFAULTS(CMD_DEFAULTS),
    .SUPPLY_WARN_SEL(SUPPLY_WARN_SEL), .DIE_WARN_SEL(DIE_WARN_SEL)
  );
  fsr_host u_host (.scl(scl), .sda_low(host_low), .sda(sda));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      results();
    end
  end
  // ========
  // Helpers
  task automatic results();
    $display("Counts: %0d mismatches in %0d compares", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CLK);
  endtask
  // Settle one step past the edge before looking
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    #1;
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d, input bit dat);
    logic ok;
    u_host.wr(p, d, dat, ok);
    chk("write ack", 8'h01, {7'h00, ok});
    wt(5);
  endtask
  task automatic rdc(input logic [7:0] p, input logic [7:0] e);
    logic ok;
    logic [7:0] d;
    u_host.rd(p, d, ok);
    chk("read ack", 8'h01, {7'h00, ok});
    chk($sformatf("reg %h", p), e, d);
  endtask
  // ========
  // Scenarios
  task automatic t_powerup();
    chk("pg all off", 8'h01, {7'h00, POWER_GOOD_OE});
    chk("pins drive low", 8'h00, {5'h00, SDA_OUT, POWER_GOOD_OUT, IRQ_N_OUT});
    wt(3600);
    chk("inhibit", 8'h00, {7'h00, REGS_ALLOWED});
    SUPPLY_RISE_OK <= 1'b1;
    wt(20);
    chk("allowed", 8'h01, {7'h00, REGS_ALLOWED});
  endtask
  task automatic t_regs();
    logic [7:0] r;
    logic a;
    rdc(REG_WARNING_THRESHOLD_CONTROL, WARNING_THRESHOLD_CONTROL_RST);
    rdc(REG_PGMSK, PGMSK_RST);
    rdc(REG_IRQMSK, IRQMSK_RST);
    rdc(REG_INTERRUPT_EVENT_STATUS, 8'h00);
    rdc(8'h20, 8'h00);
    u_host.start();
    u_host.xfer(8'h78, r, a);
    u_host.xfer(REG_WARNING_THRESHOLD_CONTROL, r, a);
    u_host.xfer(8'h1f, r, a);
    wt(20);
    chk("staged sel", 8'h00, {5'h00, SUPPLY_WARN_SEL});
    u_host.stop();
    for (int i = 0; i < 8; i++) begin
      wr(REG_WARNING_THRESHOLD_CONTROL, {3'h0, i[2:0], i[1:0]}, 1'b1);
      chk("uv sel", {5'h00, i[2:0]}, {5'h00, SUPPLY_WARN_SEL});
      chk("ot sel", {6'h00, i[1:0]}, {6'h00, DIE_WARN_SEL});
    end
    INTERFACE_SUPPLY_LOW <= 1'b1;
    wt(10);
    chk("defaults", 8'h01, {7'h00, CMD_DEFAULTS});
    INTERFACE_SUPPLY_LOW <= 1'b0;
    wt(10);
    rdc(REG_WARNING_THRESHOLD_CONTROL, 8'h00);
  endtask
  task automatic t_power_good_out();
    REG_ENABLED <= 8'hef;
    REG_OUT_OK <= 8'hef;
    wt(10);
    chk("pg release", 8'h00, {7'h00, POWER_GOOD_OE});
    REG_OUT_LOW <= 8'h80;
    wt(100);
    REG_OUT_LOW <= 8'h00;
    wt(5);
    chk("pg dip", 8'h00, {7'h00, POWER_GOOD_OE});
    REG_OUT_LOW <= 8'h80;
    wt(600);
    chk("pg low", 8'h01, {7'h00, POWER_GOOD_OE});
    rdc(REG_PGLIVE, 8'h6f);
    wt(1);
    REG_OUT_LOW <= 8'h00;
    rdc(REG_PGLIVE, 8'hef);
    rdc(REG_PGHELD, 8'h6f);
    chk("pg hold", 8'h01, {7'h00, POWER_GOOD_OE});
    chk("no timeout", 8'h00, {7'h00, IRQ_N_OE});
    wt(800);
    chk("pg hold end", 8'h00, {7'h00, POWER_GOOD_OE});
    rdc(REG_PGHELD, 8'hef);
    wt(1);
    REG_OUT_LOW <= 8'h80;
    REG_OUT_OK <= 8'h6f;
    wt(4300);
    chk("timeout pin", 8'h01, {7'h00, IRQ_N_OE});
    rdc(REG_INTERRUPT_EVENT_STATUS, 8'h04);
    wr(REG_PGMSK, 8'h6f, 1'b1);
    wt(1800);
    chk("pg masked", 8'h00, {7'h00, POWER_GOOD_OE});
    rdc(REG_PGLIVE, 8'h6f);
    wt(1);
    REG_OUT_LOW <= 8'h00;
    REG_OUT_OK <= 8'hef;
    wr(REG_PGMSK, 8'hef, 1'b1);
    REG_ENABLED <= 8'h00;
    wt(5);
    chk("pg none on", 8'h01, {7'h00, POWER_GOOD_OE});
  endtask
  task automatic t_clear();
    SUPPLY_LOW_WARN <= 1'b1;
    wt(10);
    rdc(REG_INTERRUPT_EVENT_STATUS, 8'h0c);
    wr(REG_CLEAR_INTERRUPT_CMD, 8'h00, 1'b0);
    chk("irq cleared", 8'h00, {7'h00, IRQ_N_OE});
    rdc(REG_INTERRUPT_EVENT_STATUS, 8'h00);
    wt(1);
    SUPPLY_LOW_WARN <= 1'b0;
  endtask
  task automatic t_faults();
    wr(REG_IRQMSK, 8'h40, 1'b1);
    for (int k = 0; k < 2; k++) begin
      wt(1);
      if (k == 0) begin
        SUPPLY_LOW_FAULT <= 1'b1;
      end else begin
        DIE_TOO_HOT_FAULT <= 1'b1;
      end
      wt(10);
      chk("standby", {6'h00, PS_STANDBY}, {6'h00, POWER_STATE});
      chk("fault pin", {7'h00, k == 0}, {7'h00, IRQ_N_OE});
      SUPPLY_LOW_FAULT <= 1'b0;
      DIE_TOO_HOT_FAULT <= 1'b0;
      wt(50);
      chk("back on", {6'h00, PS_ON}, {6'h00, POWER_STATE});
      chk("pin kept", {7'h00, k == 0}, {7'h00, IRQ_N_OE});
      rdc(REG_INTERRUPT_EVENT_STATUS, (k == 0) ? 8'h10 : 8'h40);
      wr(REG_CLEAR_INTERRUPT_CMD, 8'h00, 1'b0);
    end
  endtask
  task automatic t_hreset();
    int n;
    DIE_TOO_HOT_WARN <= 1'b1;
    wr(REG_WARNING_THRESHOLD_CONTROL, 8'h1f, 1'b1);
    wr(REG_HRESET, 8'h00, 1'b0);
    chk("timer state", {6'h00, PS_HARD_RESET_CMD_TIMER}, {6'h00, POWER_STATE});
    chk("sel default", 8'h00, {5'h00, SUPPLY_WARN_SEL});
    rdc(REG_INTERRUPT_EVENT_STATUS, 8'h22);
    chk("irq kept", 8'h01, {7'h00, IRQ_N_OE});
    for (n = 0; n < 2300; n++) begin
      wt(1);
      #1;
      if (POWER_STATE === PS_RESET_WAIT) break;
    end
    chk("timer length", 8'h01, {7'h00, n > 1200 && n < 1700});
    rdc(REG_IRQMSK, 8'h00);
  endtask
  initial begin
    NRST = 1'b0;
    {SUPPLY_LOW_FAULT, SUPPLY_RISE_OK, SUPPLY_LOW_WARN, DIE_TOO_HOT_FAULT} = 4'h0;
    {DIE_TOO_HOT_WARN, INTERFACE_SUPPLY_LOW} = 2'h0;
    MASTER_POWER_REQUEST = 1'b1;
    {REG_ENABLED, REG_OUT_LOW, REG_OUT_OK} = 24'h000000;
    wt(10);
    NRST <= 1'b1;
    wt(5);
    t_powerup();
    t_regs();
    t_power_good_out();
    t_clear();
    t_faults();
    t_hreset();
    results();
  end
endmodule
